// ===== logic/sam_device.sv
// Behaviour
// - single phase reuses retained upper half
// - sync capture on clock; lower starts sensing
// - both halves captured in two clocks
// - device uses output enable seen before capture end
// - host aborts at most once per cycle
// - host holds address before output enable
// - output enable falls with address valid for an upper phase
// - burst works at slow link clocks
// - write commits on write enable rise
// - upper half zero until split mode
// - wait states at word line crossing
// - output enable level picks address half
// - mode bit enables split, clears upper
// - read mode bit selects sync or async
// - wait follows data drive, latency gated
`timescale 1ns/10ps
`default_nettype none
`include "sam_regs.svh"
module sam_device #(
	parameter int unsigned UPPER_W   = `SAM_UPPER_W,
	parameter int unsigned LATENCY   = `SAM_LATENCY,
	parameter int unsigned LINE_BITS = `SAM_LINE_BITS,
	parameter int unsigned LINE_WAIT = `SAM_LINE_WAIT
) (
	input  wire logic                  clk,
	input  wire logic                  rst,
	sam_link_if.dev                    link,
	output logic                       sense_req,
	output logic [UPPER_W+15:0]        sense_addr,
	input  wire logic                  sense_ack,
	input  wire sam_pkg::sam_word_t    sense_data,
	output logic                       wr_strobe,
	output logic [UPPER_W+15:0]        wr_addr,
	output sam_pkg::sam_word_t         wr_data,
	output logic                       split_address_mux_mode,
	output logic                       sync_mode
);
	import sam_pkg::*;

	typedef struct packed {
		sam_dev_state_e       st;
		sam_word_t            read_configuration_register;
		logic                 armed;
		logic                 avn_prev;
		logic                 oe_prev;
		logic                 we_prev;
		logic [UPPER_W-1:0]   upper;
		sam_word_t            lower;
		sam_word_t            wdata;
		sam_word_t            data;
		sam_word_t            ad_prev;
		logic                 sync_flag;
		logic [3:0]           cnt;
		logic                 lat_done;
		logic                 ad_oe;
		logic                 wait_out;
		logic                 sense_req;
		logic                 wr_strobe;
	} sam_dev_s;

	sam_dev_s s;
	sam_dev_s next_s;
	logic     sync;
	logic     split;
	logic     ce;
	logic     capture;
	logic     upper_sel;
	logic     we_rise;
	logic     advance;
	logic     line_end;
	sam_word_t cap_word;

	////////////////////////////////////////////////////////////////////////////
	assign sync = !s.read_configuration_register[`SAM_RCR_ASYNC];
	assign split = s.read_configuration_register[`SAM_RCR_SPLIT];
	assign ce = !link.chip_enable_n;
	// async capture takes the enable level seen while address valid was low
	assign capture = ce && (sync ? (link.link_tick && !link.address_valid_n)
		: (!s.avn_prev && link.address_valid_n));
	assign upper_sel = split && !(sync ? link.output_enable_n : s.oe_prev);
	assign we_rise = ce && !s.we_prev && link.write_enable_n;
	// words leave only on a link tick the host saw them on, so a stalled
	// link clock simply parks the burst; no minimum rate is assumed
	assign advance = sync && link.link_tick && s.ad_oe && !link.output_enable_n;
	assign line_end = &s.lower[LINE_BITS-1:0];
	// async rise is seen a cycle late: use the lines as they stood before it
	assign cap_word = sync ? link.ad_bus : s.ad_prev;

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_s = s;
		next_s.sense_req = 1'b0;
		next_s.wr_strobe = 1'b0;
		next_s.avn_prev = link.address_valid_n;
		next_s.oe_prev = link.output_enable_n;
		next_s.we_prev = link.write_enable_n;
		next_s.ad_prev = link.ad_bus;
		if (!link.write_enable_n) begin
			next_s.wdata = link.ad_bus;
		end
		// the array write is edge driven by write enable, not by the link tick
		if (we_rise) begin
			if (s.armed && s.wdata == `SAM_CMD_CONFIRM) begin
				next_s.armed = 1'b0;
				next_s.read_configuration_register = s.lower;
				if (!split && s.lower[`SAM_RCR_SPLIT]) begin
					next_s.upper = '0;
				end
			end else if (s.wdata == `SAM_CMD_SETUP) begin
				next_s.armed = 1'b1;
			end else begin
				next_s.armed = 1'b0;
				next_s.wr_strobe = 1'b1;
			end
		end
		if (sync && link.link_tick && s.cnt != 4'hF) begin
			next_s.cnt = s.cnt + 4'h1;
		end
		case (s.st)
			SAM_D_IDLE: begin
				next_s.lat_done = 1'b0;
			end
			SAM_D_SENSE: begin
				if (sense_ack) begin
					next_s.data = sense_data;
					if (sync && !s.lat_done) begin
						next_s.st = SAM_D_LAT;
					end else begin
						next_s.st = SAM_D_BURST;
					end
				end
			end
			SAM_D_LAT: begin
				if (s.cnt >= 4'(LATENCY)) begin
					next_s.lat_done = 1'b1;
					next_s.st = SAM_D_BURST;
				end
			end
			SAM_D_BURST: begin
				if (advance) begin
					next_s.lower = s.lower + 16'h0001;
					next_s.cnt = 4'h0;
					// a new word line waits LINE_WAIT link ticks before its fresh sense
					if (line_end) begin
						next_s.st = SAM_D_LINE;
					end else begin
						next_s.sense_req = 1'b1;
						next_s.st = SAM_D_SENSE;
					end
				end
			end
			SAM_D_LINE: begin
				if (s.cnt >= 4'(LINE_WAIT)) begin
					next_s.sense_req = 1'b1;
					next_s.st = SAM_D_SENSE;
				end
			end
			default: begin
				next_s.st = SAM_D_IDLE;
			end
		endcase
		// a new lower-half capture restarts any pending sense; the host limits how often
		if (capture) begin
			if (upper_sel) begin
				next_s.upper = cap_word[UPPER_W-1:0];
			end else begin
				// upper half is whatever was retained last
				next_s.lower = cap_word;
				next_s.sense_req = 1'b1;
				next_s.cnt = 4'h0;
				next_s.lat_done = 1'b0;
				next_s.st = SAM_D_SENSE;
			end
		end
		if (!split) begin
			next_s.upper = '0;
		end
		if (!ce) begin
			next_s.st = SAM_D_IDLE;
		end
		// never drive into an address phase: wait only while the lines carry data
		next_s.ad_oe = ce && !link.output_enable_n && link.address_valid_n &&
			next_s.st != SAM_D_IDLE;
		next_s.wait_out = next_s.st != SAM_D_BURST;
		next_s.sync_flag = !next_s.read_configuration_register[`SAM_RCR_ASYNC];
		if (rst) begin
			next_s = '0;
			next_s.st = SAM_D_IDLE;
			next_s.read_configuration_register = `SAM_RCR_RESET;
			next_s.avn_prev = 1'b1;
			next_s.oe_prev = 1'b1;
			next_s.we_prev = 1'b1;
			next_s.wait_out = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		s <= next_s;
	end

	////////////////////////////////////////////////////////////////////////////
	assign link.dev_ad_out = s.data;
	assign link.dev_ad_oe = s.ad_oe;
	assign link.wait_out = s.wait_out;
	assign link.wait_oe = s.ad_oe;
	assign sense_req = s.sense_req;
	assign sense_addr = {s.upper, s.lower};
	assign wr_strobe = s.wr_strobe;
	assign wr_addr = {s.upper, s.lower};
	assign wr_data = s.wdata;
	assign split_address_mux_mode = s.read_configuration_register[`SAM_RCR_SPLIT];
	assign sync_mode = s.sync_flag;

endmodule : sam_device
`default_nettype wire

// ===== logic/sam_host.sv
`timescale 1ns/10ps
`default_nettype none
`include "sam_regs.svh"
module sam_host #(
	parameter int unsigned UPPER_W  = `SAM_UPPER_W,
	parameter int unsigned TICK_DIV = 1,
	parameter int unsigned DEPTH    = 2
) (
	input  wire logic                  clk,
	input  wire logic                  rst,
	sam_link_if.host                   link,
	input  wire logic                  cmd_valid,
	output logic                       cmd_ready,
	input  wire logic                  cmd_write,
	input  wire logic                  cmd_two_phase,
	input  wire logic                  cmd_sync,
	input  wire logic [UPPER_W+15:0]   cmd_addr,
	input  wire sam_pkg::sam_word_t    cmd_data,
	input  wire logic [7:0]            cmd_len,
	output logic                       rd_valid,
	input  wire logic                  rd_ready,
	output sam_pkg::sam_word_t         rd_data
);
	import sam_pkg::*;

	localparam int unsigned FW = $clog2(DEPTH + 1);

	typedef struct packed {
		sam_host_state_e          st;
		logic                     tick;
		logic [7:0]               div;
		logic                     sync;
		logic                     two;
		logic                     write;
		logic [UPPER_W+15:0]      addr;
		sam_word_t                wdata;
		logic [7:0]               len;
		logic [3:0]               cnt;
		logic                     gap;
		logic                     avn;
		logic                     oe;
		logic                     we;
		logic                     ce;
		sam_word_t                ad_out;
		logic                     ad_oe;
		logic                     cmd_ready;
		logic [DEPTH-1:0][15:0]   mem;
		logic [FW-1:0]            fill;
		logic                     rd_valid;
	} sam_host_s;

	sam_host_s s;
	sam_host_s next_s;
	logic      pop;
	logic      push;
	logic      room;

	assign pop  = s.rd_valid && rd_ready;
	assign room = s.fill < FW'(DEPTH);

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_s = s;
		push = 1'b0;
		next_s.div = (s.div == 8'(TICK_DIV - 1)) ? 8'h00 : s.div + 8'h01;
		case (s.st)
			SAM_H_IDLE: begin
				if (cmd_valid && s.cmd_ready) begin
					next_s.cmd_ready = 1'b0;
					next_s.sync = cmd_sync;
					next_s.two = cmd_two_phase;
					next_s.write = cmd_write;
					next_s.addr = cmd_addr;
					next_s.wdata = cmd_data;
					next_s.len = (cmd_len == 8'h00) ? 8'h01 : cmd_len;
					next_s.ce = 1'b0;
					next_s.avn = 1'b0;
					next_s.ad_oe = 1'b1;
					next_s.gap = 1'b0;
					if (cmd_two_phase) begin
						next_s.oe = 1'b0;
						next_s.ad_out = 16'(cmd_addr >> 16);
						next_s.st = SAM_H_UPPER;
					end else begin
						next_s.ad_out = cmd_addr[15:0];
						next_s.st = SAM_H_LOWER;
					end
				end
			end
			SAM_H_UPPER: begin
				if (s.tick) begin
					next_s.oe = 1'b1;
					next_s.ad_out = s.addr[15:0];
					next_s.st = SAM_H_LOWER;
					// async phases need a rising edge each; sync ones share one low pulse
					if (!s.sync) begin
						next_s.avn = 1'b1;
						next_s.gap = 1'b1;
					end
				end
			end
			SAM_H_LOWER: begin
				if (s.gap) begin
					next_s.gap = 1'b0;
					next_s.avn = 1'b0;
				end else if (s.tick) begin
					next_s.avn = 1'b1;
					next_s.cnt = 4'h0;
					next_s.st = SAM_H_HOLD;
				end
			end
			SAM_H_HOLD: begin
				next_s.cnt = s.cnt + 4'h1;
				if (s.cnt + 4'h1 >= 4'(`SAM_HOLD_CYC)) begin
					next_s.cnt = 4'h0;
					if (s.write) begin
						next_s.ad_out = s.wdata;
						next_s.we = 1'b0;
						next_s.st = SAM_H_WRLOW;
					end else begin
						next_s.ad_oe = 1'b0;
						next_s.oe = 1'b0;
						next_s.st = SAM_H_READ;
					end
				end
			end
			SAM_H_READ: begin
				if (link.dev_ad_oe && !link.wait_out && room && (!s.sync || s.tick)) begin
					push = 1'b1;
					next_s.len = s.len - 8'h01;
					if (s.len == 8'h01 || !s.sync) begin
						next_s.st = SAM_H_END;
					end
				end
			end
			SAM_H_WRLOW: begin
				next_s.cnt = s.cnt + 4'h1;
				if (s.cnt + 4'h1 >= 4'(`SAM_WE_LOW_CYC)) begin
					next_s.we = 1'b1;
					next_s.st = SAM_H_WRHIGH;
				end
			end
			SAM_H_WRHIGH: begin
				next_s.ad_oe = 1'b0;
				next_s.st = SAM_H_END;
			end
			SAM_H_END: begin
				// one full idle cycle closes the bus cycle, so no abort stacks up
				next_s.oe = 1'b1;
				next_s.ce = 1'b1;
				next_s.avn = 1'b1;
				next_s.ad_oe = 1'b0;
				next_s.cmd_ready = 1'b1;
				next_s.st = SAM_H_IDLE;
			end
			default: begin
				next_s.st = SAM_H_IDLE;
			end
		endcase
		if (pop) begin
			for (int i = 0; i < int'(DEPTH) - 1; i++) begin
				next_s.mem[i] = s.mem[i+1];
			end
			next_s.fill = s.fill - FW'(1);
		end
		if (push) begin
			next_s.mem[next_s.fill] = link.ad_bus;
			next_s.fill = next_s.fill + FW'(1);
		end
		next_s.rd_valid = next_s.fill != FW'(0);
		// the link clock stalls during a read while the buffer has no room for a word
		next_s.tick = (s.div == 8'(TICK_DIV - 1)) &&
			(next_s.st != SAM_H_READ || next_s.fill < FW'(DEPTH));
		if (rst) begin
			next_s = '0;
			next_s.st = SAM_H_IDLE;
			next_s.avn = 1'b1;
			next_s.oe = 1'b1;
			next_s.we = 1'b1;
			next_s.ce = 1'b1;
			next_s.cmd_ready = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		s <= next_s;
	end

	////////////////////////////////////////////////////////////////////////////
	assign link.link_tick = s.tick;
	assign link.chip_enable_n = s.ce;
	assign link.address_valid_n = s.avn;
	assign link.output_enable_n = s.oe;
	assign link.write_enable_n = s.we;
	assign link.host_ad_out = s.ad_out;
	assign link.host_ad_oe = s.ad_oe;
	assign cmd_ready = s.cmd_ready;
	assign rd_valid = s.rd_valid;
	assign rd_data = s.mem[0];

endmodule : sam_host
`default_nettype wire

// ===== logic/sam_link_if.sv
`timescale 1ns/10ps
`default_nettype none
`include "sam_regs.svh"
interface sam_link_if (
	input wire logic clk
);
	import sam_pkg::*;

	logic      link_tick;
	logic      chip_enable_n;
	logic      address_valid_n;
	logic      output_enable_n;
	logic      write_enable_n;
	sam_word_t host_ad_out;
	logic      host_ad_oe;
	sam_word_t dev_ad_out;
	logic      dev_ad_oe;
	logic      wait_out;
	logic      wait_oe;
	sam_word_t ad_bus;

	// shared lines resolved here; released lines read high
	assign ad_bus = dev_ad_oe ? dev_ad_out : (host_ad_oe ? host_ad_out : `SAM_BUS_IDLE);

	modport dev (
		input  link_tick, chip_enable_n, address_valid_n, output_enable_n,
		input  write_enable_n, ad_bus,
		output dev_ad_out, dev_ad_oe, wait_out, wait_oe
	);

	modport host (
		input  ad_bus, dev_ad_oe, wait_out, wait_oe,
		output link_tick, chip_enable_n, address_valid_n, output_enable_n,
		output write_enable_n, host_ad_out, host_ad_oe
	);

endinterface : sam_link_if
`default_nettype wire

// ===== logic/sam_pkg.sv
`default_nettype none
package sam_pkg;

	typedef enum logic [2:0] {
		SAM_D_IDLE  = 3'h0,
		SAM_D_SENSE = 3'h1,
		SAM_D_LAT   = 3'h3,
		SAM_D_BURST = 3'h2,
		SAM_D_LINE  = 3'h6
	} sam_dev_state_e;

	typedef enum logic [2:0] {
		SAM_H_IDLE   = 3'h0,
		SAM_H_UPPER  = 3'h1,
		SAM_H_LOWER  = 3'h3,
		SAM_H_HOLD   = 3'h2,
		SAM_H_READ   = 3'h6,
		SAM_H_WRLOW  = 3'h7,
		SAM_H_WRHIGH = 3'h5,
		SAM_H_END    = 3'h4
	} sam_host_state_e;

	typedef logic [15:0] sam_word_t;

endpackage : sam_pkg
`default_nettype wire

// ===== logic/sam_regs.svh
`ifndef SAM_REGS_SVH
`define SAM_REGS_SVH

// address halves
`define SAM_LOWER_W       16
`define SAM_UPPER_W       10

// read configuration register
`define SAM_RCR_RESET     16'h8000
`define SAM_RCR_SPLIT     4
`define SAM_RCR_ASYNC     15

// configuration write sequence
`define SAM_CMD_SETUP     16'h0060
`define SAM_CMD_CONFIRM   16'h0003

// timing
`define SAM_CLK_PERIOD_NS 25
`define SAM_HOLD_NS       5
`define SAM_HOLD_CYC      ((`SAM_HOLD_NS + `SAM_CLK_PERIOD_NS - 1) / `SAM_CLK_PERIOD_NS)
`define SAM_WE_LOW_NS     40
`define SAM_WE_LOW_CYC    ((`SAM_WE_LOW_NS + `SAM_CLK_PERIOD_NS - 1) / `SAM_CLK_PERIOD_NS)
`define SAM_LINK_MIN_KHZ  9600
`define SAM_LATENCY       4
`define SAM_LINE_BITS     4
`define SAM_LINE_WAIT     2

// released shared lines read high
`define SAM_BUS_IDLE      16'hFFFF

`endif

// ===== tb/sam_link_chk.sv
`timescale 1ns/10ps
`default_nettype none
module sam_link_chk (
	input wire logic clk,
	input wire logic rst,
	input wire logic chip_enable_n,
	input wire logic address_valid_n,
	input wire logic output_enable_n,
	input wire logic write_enable_n,
	input wire logic host_ad_oe,
	input wire logic dev_ad_oe,
	input wire logic wait_oe
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////////////////////
	sequence upper_phase;
		$fell(address_valid_n) && !output_enable_n;
	endsequence
	sequence lower_phase;
		!address_valid_n && output_enable_n;
	endsequence
	////////////////////////////////////////////////////////////////////////////////
	a_wait_with_data: assert property (wait_oe == dev_ad_oe)
		else $error("wait drive differs from data drive");
	a_no_contention: assert property (!(dev_ad_oe && host_ad_oe))
		else $error("both ends drive the shared lines");
	a_release_on_ce: assert property (chip_enable_n |=> !dev_ad_oe)
		else $error("device drives while deselected");
	a_release_on_oe: assert property (output_enable_n |=> !dev_ad_oe)
		else $error("device drives after output enable rose");
	a_drive_needs_oe: assert property ($rose(dev_ad_oe) |-> !output_enable_n && !chip_enable_n)
		else $error("device drive started without output enable");
	a_upper_then_lower: assert property (upper_phase |-> ##[1:16] lower_phase)
		else $error("upper phase not followed by lower phase");
	a_capture_bounded: assert property ($fell(address_valid_n) |-> ##[1:16] address_valid_n)
		else $error("address phase too long");
	a_write_no_read: assert property (!write_enable_n |-> output_enable_n && host_ad_oe)
		else $error("write strobe without host data drive");
	a_hold_before_oe: assert property ($fell(output_enable_n) && address_valid_n && !host_ad_oe
		|-> $past(address_valid_n))
		else $error("output enable fell before address hold");
endmodule : sam_link_chk
`default_nettype wire

// ===== tb/test_split_mux_sync_address_capture.sv
`timescale 1ns/10ps
`default_nettype none
module test_split_mux_sync_address_capture;
	import sam_pkg::*;
	typedef struct {
		logic        wr;
		logic        two;
		logic        sy;
		logic [25:0] a;
		sam_word_t   d;
		logic [7:0]  n;
	} sam_row_s;
	logic        clk = 1'h0;
	logic        rst = 1'h1;
	logic        cmd_valid = 1'h0;
	logic        cmd_ready;
	logic        cmd_write = 1'h0;
	logic        cmd_two_phase = 1'h0;
	logic        cmd_sync = 1'h0;
	logic [25:0] cmd_addr = 26'h0;
	sam_word_t   cmd_data = 16'h0;
	logic [7:0]  cmd_len = 8'h01;
	logic        rd_valid;
	logic        rd_ready = 1'h1;
	sam_word_t   rd_data;
	logic        sense_req;
	logic [25:0] sense_addr;
	logic        sense_ack = 1'h0;
	sam_word_t   sense_data = 16'h0;
	logic        wr_strobe;
	logic [25:0] wr_addr;
	sam_word_t   wr_data;
	logic        split_address_mux_mode;
	logic        sync_mode;
	logic        req_d = 1'h0;
	logic [25:0] sa_d = 26'h0;
	logic [25:0] wa;
	sam_word_t   wd;
	sam_word_t   cap_up;
	sam_word_t   cap_lo;
	sam_word_t   got_q[$];
	logic [9:0]  up = 10'h000;
	logic        sp = 1'h0;
	logic        sy = 1'h0;
	logic        setup_seen = 1'h0;
	int          fail_count = 0;
	int          checked = 0;
	int          cyc = 0;
	sam_row_s    rows[11];

	sam_link_if link (.clk(clk));
	// link clock at a quarter rate, just above the slowest it must run
	sam_host #(.TICK_DIV(4)) u_sam_host (.clk(clk), .rst(rst), .link(link), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_two_phase(cmd_two_phase),
		.cmd_sync(cmd_sync), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_len(cmd_len),
		.rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data));
	sam_device u_sam_device (.clk(clk), .rst(rst), .link(link), .sense_req(sense_req),
		.sense_addr(sense_addr), .sense_ack(sense_ack), .sense_data(sense_data),
		.wr_strobe(wr_strobe), .wr_addr(wr_addr), .wr_data(wr_data),
		.split_address_mux_mode(split_address_mux_mode), .sync_mode(sync_mode));
	sam_link_chk u_chk (.clk(clk), .rst(rst), .chip_enable_n(link.chip_enable_n),
		.address_valid_n(link.address_valid_n), .output_enable_n(link.output_enable_n),
		.write_enable_n(link.write_enable_n), .host_ad_oe(link.host_ad_oe),
		.dev_ad_oe(link.dev_ad_oe), .wait_oe(link.wait_oe));
	////////////////////////////////////////////////////////////////////////////////
	always #12.5 clk = ~clk;

	function automatic sam_word_t word_of(input logic [25:0] a);
		return a[15:0] ^ {a[25:16], 6'h15};
	endfunction : word_of

	// array answers one cycle late, so the sense is really outstanding
	always @(negedge clk) begin
		sense_ack = req_d;
		sense_data = word_of(sa_d);
		req_d = sense_req;
		sa_d = sense_addr;
	end

	always @(posedge clk) begin
		cyc++;
		if (rd_valid === 1'h1 && rd_ready === 1'h1) got_q.push_back(rd_data);
		if (wr_strobe === 1'h1) begin
			wa = wr_addr;
			wd = wr_data;
		end
		if (link.link_tick && !link.address_valid_n && !link.chip_enable_n) begin
			if (!link.output_enable_n) cap_up = link.ad_bus;
			else cap_lo = link.ad_bus;
		end
		if (cyc == 20000) begin
			fail_count++;
			$display("mismatch at %0t: timeout", $time);
			conclude();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [25:0] g, input logic [25:0] e);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk

	task automatic conclude();
		$display("counts: %0d checked, %0d mismatches", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : conclude

	task automatic finish_cmd();
		repeat (2) @(negedge clk);
		while (cmd_ready !== 1'h1) @(negedge clk);
		repeat (3) @(negedge clk);
	endtask : finish_cmd

	task automatic run(input sam_row_s r, input logic stall);
		logic [9:0] u;
		rd_ready = ~stall;
		while (cmd_ready !== 1'h1) @(negedge clk);
		cmd_valid = 1'h1;
		cmd_write = r.wr;
		cmd_two_phase = r.two;
		cmd_sync = r.sy;
		cmd_addr = r.a;
		cmd_data = r.d;
		cmd_len = r.n;
		@(negedge clk);
		cmd_valid = 1'h0;
		if (stall) begin
			repeat (60) @(negedge clk);
			chk(rd_valid, 1'h1);
			chk(cmd_ready, 1'h0);
			chk(26'(got_q.size()), 26'h0);
			rd_ready = 1'h1;
		end
		finish_cmd();
		if (r.two && sp) up = r.a[25:16];
		u = sp ? up : 10'h000;
		if (r.wr && setup_seen && r.d == 16'h0003) begin
			if (r.a[4] && !sp) up = 10'h000;
			sp = r.a[4];
			sy = ~r.a[15];
		end else if (r.wr && r.d != 16'h0060) begin
			chk(wa, {u, r.a[15:0]});
			chk(wd, r.d);
		end else if (!r.wr) begin
			while (got_q.size() < r.n) @(negedge clk);
			for (int k = 0; k < r.n; k++) begin
				chk(got_q.pop_front(), word_of({u, r.a[15:0] + 16'(k)}));
			end
		end
		if (r.two && r.sy) begin
			chk(cap_up, {6'h00, r.a[25:16]});
			chk(cap_lo, r.a[15:0]);
		end
		setup_seen = r.wr && r.d == 16'h0060;
		chk(split_address_mux_mode, sp);
		chk(sync_mode, sy);
		$display("test done: addr %h", r.a);
	endtask : run
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		rows = '{
			'{1'h1, 1'h1, 1'h0, 26'h3FF1234, 16'hBEEF, 8'h01},
			'{1'h1, 1'h0, 1'h0, 26'h0000000, 16'h0060, 8'h01},
			'{1'h1, 1'h0, 1'h0, 26'h0008010, 16'h0003, 8'h01},
			'{1'h1, 1'h0, 1'h0, 26'h1554321, 16'h1111, 8'h01},
			'{1'h0, 1'h1, 1'h0, 26'h0F05555, 16'h0000, 8'h01},
			'{1'h1, 1'h0, 1'h0, 26'h0001357, 16'h3333, 8'h01},
			'{1'h1, 1'h0, 1'h0, 26'h0000000, 16'h0060, 8'h01},
			'{1'h1, 1'h0, 1'h0, 26'h0000010, 16'h0003, 8'h01},
			'{1'h1, 1'h1, 1'h1, 26'h2AA0042, 16'h2222, 8'h01},
			'{1'h0, 1'h0, 1'h1, 26'h0000100, 16'h0000, 8'h01},
			'{1'h0, 1'h1, 1'h1, 26'h1C300AE, 16'h0000, 8'h04}
		};
		repeat (4) @(negedge clk);
		rst = 1'h0;
		foreach (rows[i]) run(rows[i], 1'h0);
		// burst over a word line end with the reader stalled
		run('{1'h0, 1'h1, 1'h1, 26'h0A5FFFC, 16'h0000, 8'h06}, 1'h1);
		rst = 1'h1;
		repeat (4) @(negedge clk);
		rst = 1'h0;
		@(negedge clk);
		sp = 1'h0;
		sy = 1'h0;
		chk(split_address_mux_mode, 1'h0);
		chk(sync_mode, 1'h0);
		chk(link.dev_ad_oe, 1'h0);
		chk(link.wait_out, 1'h1);
		chk(cmd_ready, 1'h1);
		$display("test done: reset");
		run('{1'h1, 1'h0, 1'h0, 26'h2341111, 16'h4444, 8'h01}, 1'h0);
		conclude();
	end
endmodule : test_split_mux_sync_address_capture
`default_nettype wire
